// [design/moe_exec.sv]
// execution sequencer for memory-referencing major op-codes
`timescale 1ns/1ps
module moe_exec
	import moe_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [17:0] instr_i,
	output logic busy_o,
	output logic done_o,
	output logic minor_o,
	output logic ic_load_o,
	output logic [15:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [17:0] mem_wdata_o,
	input wire logic [17:0] mem_rdata_i,
	output logic prot_viol_o,
	output logic [3:0] io_dev_o,
	output logic io_rd_o,
	output logic io_wr_o,
	output logic [17:0] io_wdata_o,
	input wire logic [17:0] io_rdata_i,
	output logic [17:0] acc_o,
	output logic [17:0] ext_o,
	output logic [17:0] index_reg_o,
	output logic decision_o,
	output logic carry_o,
	output logic overflow_o,
	output logic [15:0] ic_o,
	output logic [3:0] page_o,
	output logic [15:0] limit_o,
	output logic [17:0] lockout_o,
	output logic [17:0] act_status_o
);

	typedef enum logic [3:0] {
		S_IDLE, S_INDEX1, S_INDEX2, S_DISP, S_EXEC, S_IND_RD, S_IND_CAP, S_STORE,
		S_IN_RD, S_IN_CAP, S_OUT_CAP, S_IO_WR, S_SHIFT, S_MUL, S_RESTORE, S_PAD
	} moe_state_t;

	moe_state_t state_q;
	logic [5:0] cnt_q;
	logic [5:0] target_q;
	logic [4:0] op_q;
	logic [17:0] adr_q;
	logic [15:0] maddr_q;
	logic [17:0] acc_q;
	logic [17:0] ext_q;
	logic [17:0] index_reg_q;
	logic dec_q;
	logic carry_q;
	logic ovf_q;
	logic [15:0] ic_q;
	logic [3:0] page_q;
	logic [15:0] limit_q;
	logic [17:0] lock_q;
	logic [17:0] act_q;
	logic [3:0] dev_q;
	logic [17:0] wdata_q;
	logic [17:0] io_wdata_q;
	logic [5:0] shcnt_q;
	logic shleft_q;
	logic [2:0] timk_q;
	logic ic_load_q;
	logic [4:0] major;
	logic supported;
	logic last;
	logic fin_state;
	logic [17:0] opd;
	logic [17:0] ptr_adr;
	logic [17:0] sub_res;
	logic [17:0] sub_low;
	logic [5:0] sh_mag;
	logic protected_adr;
	logic mul_start;
	logic mul_done;
	logic [17:0] mul_hi;
	logic [17:0] mul_lo;

	// ==================== decode ====================
	assign major = instr_i[MAJ_HI:MAJ_LO];
	always_comb begin
		case (major)
			OPC_INPUT_WORD_FROM_DEVICE, OPC_OUTPUT_WORD_TO_DEVICE, OPC_LOAD_ACCUMULATOR,
			OPC_LOAD_EXTENSION, OPC_LOAD_INDEX, OPC_LOAD_INDIRECT, OPC_LOAD_LOCATION,
			OPC_BITWISE_AND, OPC_BITWISE_OR, OPC_MULTIPLY, OPC_RESUME_FROM_INTERRUPT,
			OPC_ARITHMETIC_SHIFT, OPC_STORE_ACCUMULATOR, OPC_STORE_EXTENSION,
			OPC_STORE_INDIRECT, OPC_STORE_INDEX, OPC_SUBTRACT, OPC_TEST_EQUAL,
			OPC_TEST_GREATER, OPC_TEST_LESS, OPC_TEST_INDEX_NOT_ABOVE: supported = 1'b1;
			default: supported = 1'b0;
		endcase
	end

	// operand is only meaningful in the cycle after a read strobe
	assign opd = mem_rdata_i;
	assign ptr_adr = 18'({2'b00, opd[15:0]} + (opd[PTR_INDEX_BIT] ? index_reg_q : WORD_RST));
	assign sub_res = 18'(acc_q + ~opd + 18'h0_0001);
	assign sub_low = 18'({1'b0, acc_q[16:0]} + {1'b0, ~opd[16:0]} + 18'h0_0001);
	assign sh_mag = opd[SHCNT_HI] ? 6'(~opd[SHCNT_HI:0] + 6'h01) : opd[SHCNT_HI:0];
	assign protected_adr = maddr_q < limit_q;
	assign last = cnt_q == 6'(target_q - 6'h01);
	assign fin_state = state_q == S_PAD || state_q == S_STORE || state_q == S_IO_WR;

	// ==================== handshake strobes ====================
	assign busy_o = state_q != S_IDLE;
	assign minor_o = state_q == S_IDLE && start_i && !supported;
	assign done_o = fin_state && last;
	assign ic_load_o = done_o && ic_load_q;
	assign mem_addr_o = maddr_q;
	assign mem_rd_o = state_q == S_DISP && op_q != OPC_LOAD_LOCATION && !op_q[4] ||
		state_q == S_DISP && (op_q == OPC_LOAD_LOCATION ? 1'b0 : op_q[4] &&
		op_q != OPC_STORE_ACCUMULATOR && op_q != OPC_STORE_INDEX) ||
		state_q == S_EXEC && op_q == OPC_OUTPUT_WORD_TO_DEVICE ||
		state_q == S_IND_RD || state_q == S_RESTORE && timk_q < SAVE_WORDS;
	assign mem_wr_o = state_q == S_STORE && !protected_adr;
	assign prot_viol_o = state_q == S_STORE && protected_adr;
	assign mem_wdata_o = wdata_q;
	assign io_rd_o = state_q == S_IN_RD;
	assign io_wr_o = state_q == S_IO_WR && dev_q != DEV_ACT_STATUS;
	assign io_dev_o = dev_q;
	assign io_wdata_o = io_wdata_q;
	assign mul_start = state_q == S_EXEC && op_q == OPC_MULTIPLY;

	// ==================== sequencer ====================
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_q <= S_IDLE;
			cnt_q <= '0;
			target_q <= '0;
			op_q <= OPC_MINOR;
			adr_q <= WORD_RST;
			maddr_q <= '0;
			timk_q <= '0;
			shcnt_q <= '0;
			shleft_q <= 1'b0;
			ic_load_q <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= 6'(cnt_q + 6'h01);
			case (state_q)
				S_IDLE: begin
					cnt_q <= 6'h01;
					ic_load_q <= 1'b0;
					if (start_i && supported) begin
						op_q <= major;
						adr_q <= {2'b00, page_q, instr_i[DISP_HI:0]};
						maddr_q <= {page_q, instr_i[DISP_HI:0]};
						state_q <= instr_i[INDEX_BIT] ? S_INDEX1 : S_DISP;
						case (major)
							OPC_INPUT_WORD_FROM_DEVICE, OPC_OUTPUT_WORD_TO_DEVICE: target_q <= CYC_IO;
							OPC_LOAD_INDIRECT: target_q <= CYC_INDIRECT_LOAD;
							OPC_STORE_ACCUMULATOR, OPC_STORE_EXTENSION,
							OPC_STORE_INDEX: target_q <= CYC_STORE;
							OPC_STORE_INDIRECT: target_q <= CYC_INDIRECT_STORE;
							OPC_MULTIPLY: target_q <= CYC_MULTIPLY;
							OPC_RESUME_FROM_INTERRUPT: target_q <= CYC_RESUME;
							OPC_ARITHMETIC_SHIFT: target_q <= CYC_SHIFT_BASE;
							default: target_q <= CYC_SIMPLE;
						endcase
					end
				end
				S_INDEX1: begin
					adr_q <= 18'(adr_q + index_reg_q);
					maddr_q <= 16'(adr_q + index_reg_q);
					target_q <= 6'(target_q + CYC_INDEXING);
					state_q <= S_INDEX2;
				end
				S_INDEX2: state_q <= S_DISP;
				S_DISP: begin
					if (op_q == OPC_LOAD_LOCATION) begin
						state_q <= S_PAD;
					end else if (op_q == OPC_STORE_ACCUMULATOR || op_q == OPC_STORE_EXTENSION ||
						op_q == OPC_STORE_INDEX) begin
						state_q <= S_STORE;
					end else begin
						state_q <= S_EXEC;
						if (op_q == OPC_INPUT_WORD_FROM_DEVICE || op_q == OPC_OUTPUT_WORD_TO_DEVICE) begin
							maddr_q <= 16'(maddr_q + 16'h0001); // second word is n+1
						end
					end
				end
				S_EXEC: begin
					state_q <= S_PAD;
					case (op_q)
						OPC_INPUT_WORD_FROM_DEVICE: state_q <= S_IN_RD;
						OPC_OUTPUT_WORD_TO_DEVICE: state_q <= S_OUT_CAP;
						OPC_LOAD_INDIRECT: begin
							maddr_q <= ptr_adr[15:0];
							state_q <= S_IND_RD;
						end
						OPC_STORE_INDIRECT: begin
							adr_q <= ptr_adr;
							maddr_q <= ptr_adr[15:0];
							state_q <= S_STORE;
						end
						OPC_MULTIPLY: state_q <= S_MUL;
						OPC_RESUME_FROM_INTERRUPT: begin
							maddr_q <= opd[15:0];
							timk_q <= '0;
							state_q <= S_RESTORE;
						end
						OPC_ARITHMETIC_SHIFT: begin
							shcnt_q <= sh_mag;
							shleft_q <= !opd[SHCNT_HI];
							target_q <= 6'(target_q + sh_mag);
							state_q <= sh_mag == 6'h00 ? S_PAD : S_SHIFT;
						end
						default: state_q <= S_PAD;
					endcase
				end
				S_IND_RD: state_q <= S_IND_CAP;
				S_IND_CAP: state_q <= S_PAD;
				S_IN_RD: state_q <= S_IN_CAP;
				S_IN_CAP: state_q <= S_STORE;
				S_OUT_CAP: state_q <= S_IO_WR;
				S_SHIFT: begin
					shcnt_q <= 6'(shcnt_q - 6'h01);
					if (shcnt_q == 6'h01) begin
						state_q <= S_PAD;
					end
				end
				S_MUL: begin
					if (mul_done) begin
						state_q <= S_PAD;
					end
				end
				S_RESTORE: begin
					timk_q <= 3'(timk_q + 3'h1);
					maddr_q <= 16'(maddr_q + 16'h0001);
					ic_load_q <= 1'b1;
					if (timk_q == SAVE_WORDS) begin
						state_q <= S_PAD;
					end
				end
				S_PAD, S_STORE, S_IO_WR: state_q <= last ? S_IDLE : S_PAD;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ==================== data registers ====================
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			acc_q <= WORD_RST;
			ext_q <= WORD_RST;
			index_reg_q <= WORD_RST;
		end else if (ce_i) begin
			if (state_q == S_DISP && op_q == OPC_LOAD_LOCATION) begin
				acc_q <= adr_q;
			end
			if (state_q == S_IND_CAP) begin
				acc_q <= opd;
			end
			if (state_q == S_MUL && mul_done) begin
				acc_q <= mul_hi;
				ext_q <= mul_lo;
			end
			if (state_q == S_SHIFT) begin
				acc_q <= shleft_q ? {acc_q[16:0], 1'b0} : {acc_q[17], acc_q[17:1]};
			end
			if (state_q == S_EXEC) begin
				case (op_q)
					OPC_LOAD_ACCUMULATOR: acc_q <= opd;
					OPC_LOAD_EXTENSION: ext_q <= opd;
					OPC_LOAD_INDEX: index_reg_q <= opd;
					OPC_BITWISE_AND: acc_q <= acc_q & opd;
					OPC_BITWISE_OR: acc_q <= acc_q | opd;
					OPC_SUBTRACT: acc_q <= sub_res;
					default: ;
				endcase
			end
		end
	end

	// ==================== condition flags ====================
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			dec_q <= 1'b0;
			carry_q <= 1'b0;
			ovf_q <= 1'b0;
		end else if (ce_i) begin
			if (state_q == S_EXEC) begin
				case (op_q)
					OPC_SUBTRACT: begin
						carry_q <= sub_low[17];
						if (acc_q[17] != opd[17] && sub_res[17] != acc_q[17]) begin
							ovf_q <= 1'b1;
						end
					end
					OPC_TEST_EQUAL: if (acc_q == opd) dec_q <= 1'b1;
					OPC_TEST_GREATER: if ($signed(acc_q) > $signed(opd)) dec_q <= 1'b1;
					OPC_TEST_LESS: if ($signed(acc_q) < $signed(opd)) dec_q <= 1'b1;
					OPC_TEST_INDEX_NOT_ABOVE: if ($signed(index_reg_q) <= $signed(opd)) dec_q <= 1'b1;
					default: ;
				endcase
			end
			if (state_q == S_SHIFT && shleft_q && acc_q[16] != acc_q[17]) begin
				ovf_q <= 1'b1;
			end
			if (state_q == S_RESTORE && timk_q == 3'h2) begin
				ovf_q <= opd[SAVE_OVF_BIT];
				carry_q <= opd[SAVE_CARRY_BIT];
				dec_q <= opd[SAVE_DEC_BIT];
			end
		end
	end

	// ==================== restored machine state ====================
	// save word k arrives while word k+1 is being read
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ic_q <= '0;
			page_q <= PAGE_RST;
			limit_q <= LIMIT_RST;
			lock_q <= WORD_RST;
		end else if (ce_i && state_q == S_RESTORE) begin
			case (timk_q)
				3'h1: ic_q <= opd[15:0];
				3'h2: page_q <= opd[SAVE_PAGE_HI:0];
				3'h3: limit_q <= opd[15:0];
				3'h4: lock_q <= opd;
				default: ;
			endcase
		end
	end

	// ==================== device transfers and write data ====================
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			dev_q <= '0;
			wdata_q <= WORD_RST;
			io_wdata_q <= WORD_RST;
			act_q <= WORD_RST;
		end else if (ce_i) begin
			if (state_q == S_EXEC && op_q == OPC_INPUT_WORD_FROM_DEVICE) begin
				dev_q <= {1'b0, opd[2:0]};
			end
			if (state_q == S_EXEC && op_q == OPC_OUTPUT_WORD_TO_DEVICE) begin
				dev_q <= {1'b1, opd[2:0]};
			end
			if (state_q == S_EXEC && op_q == OPC_STORE_INDIRECT) begin
				wdata_q <= acc_q;
			end
			if (state_q == S_DISP) begin
				case (op_q)
					OPC_STORE_ACCUMULATOR: wdata_q <= acc_q;
					OPC_STORE_EXTENSION: wdata_q <= ext_q;
					OPC_STORE_INDEX: wdata_q <= index_reg_q;
					default: ;
				endcase
			end
			if (state_q == S_IN_CAP) begin
				wdata_q <= io_rdata_i;
			end
			if (state_q == S_OUT_CAP) begin
				io_wdata_q <= opd;
			end
			if (state_q == S_IO_WR && dev_q == DEV_ACT_STATUS) begin
				act_q <= io_wdata_q;
			end
		end
	end

	// ==================== multiplier ====================
	moe_mul u_mul (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.start_i(mul_start),
		.a_i(acc_q),
		.b_i(opd),
		.done_o(mul_done),
		.hi_o(mul_hi),
		.lo_o(mul_lo)
	);

	assign acc_o = acc_q;
	assign ext_o = ext_q;
	assign index_reg_o = index_reg_q;
	assign decision_o = dec_q;
	assign carry_o = carry_q;
	assign overflow_o = ovf_q;
	assign ic_o = ic_q;
	assign page_o = page_q;
	assign limit_o = limit_q;
	assign lockout_o = lock_q;
	assign act_status_o = act_q;

endmodule

// [design/moe_mul.sv]
// sequential signed fraction multiplier, shift and add
`timescale 1ns/1ps
module moe_mul
	import moe_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [17:0] a_i,
	input wire logic [17:0] b_i,
	output logic done_o,
	output logic [17:0] hi_o,
	output logic [17:0] lo_o
);

	logic [33:0] prod_q;
	logic [33:0] mc_q;
	logic [16:0] mp_q;
	logic [4:0] step_q;
	logic sign_q;
	logic run_q;
	logic [33:0] prod_d;
	logic [34:0] full;
	logic [17:0] ma;
	logic [17:0] mb;

	// magnitudes; a full-scale negative operand loses its top bit
	assign ma = a_i[17] ? 18'(~a_i + 18'h0_0001) : a_i;
	assign mb = b_i[17] ? 18'(~b_i + 18'h0_0001) : b_i;
	assign prod_d = mp_q[0] ? 34'(prod_q + mc_q) : prod_q;
	assign full = sign_q ? 35'(~{1'b0, prod_d} + 35'h0_0000_0001) : {1'b0, prod_d};

	// one partial product per cycle keeps the adder narrow
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			prod_q <= '0;
			mc_q <= '0;
			mp_q <= '0;
			step_q <= '0;
			sign_q <= 1'b0;
			run_q <= 1'b0;
			done_o <= 1'b0;
			hi_o <= WORD_RST;
			lo_o <= WORD_RST;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i) begin
				prod_q <= '0;
				mc_q <= {17'h0_0000, ma[16:0]};
				mp_q <= mb[16:0];
				step_q <= '0;
				sign_q <= a_i[17] ^ b_i[17];
				run_q <= 1'b1;
			end else if (run_q) begin
				prod_q <= prod_d;
				mc_q <= {mc_q[32:0], 1'b0};
				mp_q <= {1'b0, mp_q[16:1]};
				step_q <= step_q + 5'h01;
				if (step_q == MUL_STEPS - 5'h01) begin
					run_q <= 1'b0;
					done_o <= 1'b1;
					hi_o <= full[34:17]; // sign and high seventeen
					lo_o <= {full[34], full[16:0]}; // sign and low seventeen
				end
			end
		end
	end

endmodule

// [shared/moe_pkg.sv]
// constants shared by the major op-code execution unit
package moe_pkg;

	// ==================== widths ====================
	localparam int WORD_W = 18;
	localparam int ADDR_W = 16;
	localparam int CNT_W = 6;

	// ==================== instruction fields ====================
	localparam int MAJ_HI = 17;
	localparam int MAJ_LO = 13;
	localparam int INDEX_BIT = 12;
	localparam int DISP_HI = 11;
	localparam int PTR_INDEX_BIT = 17;
	localparam int DEV_HI = 3;
	localparam int SHCNT_HI = 5;

	// ==================== major op-codes (five-bit field) ====================
	localparam logic [4:0] OPC_MINOR = 5'h00;
	localparam logic [4:0] OPC_INPUT_WORD_FROM_DEVICE = 5'h1F;
	localparam logic [4:0] OPC_OUTPUT_WORD_TO_DEVICE = 5'h07;
	localparam logic [4:0] OPC_LOAD_ACCUMULATOR = 5'h08;
	localparam logic [4:0] OPC_LOAD_EXTENSION = 5'h15;
	localparam logic [4:0] OPC_LOAD_INDEX = 5'h16;
	localparam logic [4:0] OPC_LOAD_INDIRECT = 5'h05;
	localparam logic [4:0] OPC_LOAD_LOCATION = 5'h10;
	localparam logic [4:0] OPC_BITWISE_AND = 5'h0C;
	localparam logic [4:0] OPC_BITWISE_OR = 5'h14;
	localparam logic [4:0] OPC_MULTIPLY = 5'h12;
	localparam logic [4:0] OPC_RESUME_FROM_INTERRUPT = 5'h1D;
	localparam logic [4:0] OPC_ARITHMETIC_SHIFT = 5'h06;
	localparam logic [4:0] OPC_STORE_ACCUMULATOR = 5'h18;
	localparam logic [4:0] OPC_STORE_EXTENSION = 5'h01;
	localparam logic [4:0] OPC_STORE_INDIRECT = 5'h0D;
	localparam logic [4:0] OPC_STORE_INDEX = 5'h1E;
	localparam logic [4:0] OPC_SUBTRACT = 5'h0A;
	localparam logic [4:0] OPC_TEST_EQUAL = 5'h13;
	localparam logic [4:0] OPC_TEST_GREATER = 5'h1B;
	localparam logic [4:0] OPC_TEST_LESS = 5'h0B;
	localparam logic [4:0] OPC_TEST_INDEX_NOT_ABOVE = 5'h09;

	// ==================== cycle budgets, fetch cycle included ====================
	localparam logic [5:0] CYC_IO = 6'h06;
	localparam logic [5:0] CYC_SIMPLE = 6'h04;
	localparam logic [5:0] CYC_INDIRECT_LOAD = 6'h06;
	localparam logic [5:0] CYC_STORE = 6'h06;
	localparam logic [5:0] CYC_INDIRECT_STORE = 6'h08;
	localparam logic [5:0] CYC_MULTIPLY = 6'h18;
	localparam logic [5:0] CYC_RESUME = 6'h16;
	localparam logic [5:0] CYC_SHIFT_BASE = 6'h05;
	localparam logic [5:0] CYC_INDEXING = 6'h02;
	localparam logic [4:0] MUL_STEPS = 5'h11;

	// ==================== devices and save area ====================
	localparam logic [3:0] DEV_ACT_STATUS = 4'hA;
	localparam logic [2:0] SAVE_WORDS = 3'h4;
	localparam int SAVE_OVF_BIT = 17;
	localparam int SAVE_CARRY_BIT = 16;
	localparam int SAVE_DEC_BIT = 15;
	localparam int SAVE_PAGE_HI = 3;

	// ==================== reset values ====================
	localparam logic [17:0] WORD_RST = 18'h0_0000;
	localparam logic [15:0] LIMIT_RST = 16'h0000;
	localparam logic [3:0] PAGE_RST = 4'h0;

endpackage

// [test/moe_exec_props.sv]
// timing and protection checker for the execution unit
`timescale 1ns/1ps
module moe_exec_props
	import moe_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [17:0] instr_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic minor_o,
	input wire logic ic_load_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_wr_o,
	input wire logic prot_viol_o,
	input wire logic [15:0] limit_o,
	input wire logic [3:0] io_dev_o,
	input wire logic io_rd_o,
	input wire logic io_wr_o
);
	// ==================================
	// accepted request, unindexed, and its code
	logic acc_take;
	logic [4:0] op;
	assign acc_take = start_i && ce_i && !busy_o && !instr_i[12];
	assign op = instr_i[17:13];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	wr_limit_a: assert property (mem_wr_o |-> mem_addr_o >= limit_o)
		else $error("write below limit");
	viol_nowr_a: assert property (prot_viol_o |-> !mem_wr_o && mem_addr_o < limit_o)
		else $error("bad violation pulse");
	load_time_a: assert property (acc_take && op == OPC_LOAD_ACCUMULATOR |-> ##3 done_o)
		else $error("load timing");
	store_time_a: assert property (acc_take && op == OPC_STORE_ACCUMULATOR
		|-> ##2 (mem_wr_o || prot_viol_o) ##3 done_o) else $error("store timing");
	index_time_a: assert property (start_i && ce_i && !busy_o && instr_i[12]
		&& op == OPC_LOAD_ACCUMULATOR |-> ##1 !done_o [*4] ##1 done_o) else $error("index");
	mul_time_a: assert property (acc_take && op == OPC_MULTIPLY |-> ##23 done_o)
		else $error("multiply timing");
	resume_time_a: assert property (acc_take && op == OPC_RESUME_FROM_INTERRUPT
		|-> ##21 (done_o && ic_load_o)) else $error("resume timing");
	io_out_a: assert property (io_wr_o |-> io_dev_o[3] && io_dev_o != DEV_ACT_STATUS)
		else $error("output device");
	io_in_a: assert property (io_rd_o |-> !io_dev_o[3] ##2 (done_o && (mem_wr_o || prot_viol_o)))
		else $error("input transfer");
	minor_skip_a: assert property (start_i && ce_i && !busy_o && op == OPC_MINOR
		|-> minor_o ##1 !busy_o) else $error("minor code taken");
endmodule
bind moe_exec moe_exec_props u_props (.core_clk_i, .srst_i, .ce_i, .start_i, .instr_i,
	.busy_o, .done_o, .minor_o, .ic_load_o, .mem_addr_o, .mem_wr_o, .prot_viol_o,
	.limit_o, .io_dev_o, .io_rd_o, .io_wr_o);

// [test/moe_exec_tb.sv]
// self-checking bench for the execution unit
`timescale 1ns/1ps
module moe_exec_tb;
	import moe_pkg::*;
	logic core_clk_i, srst_i, ce_i, start_i, busy_o, done_o, minor_o, ic_load_o;
	logic mem_rd_o, mem_wr_o, prot_viol_o, io_rd_o, io_wr_o, decision_o, carry_o, overflow_o;
	logic [17:0] instr_i, mem_wdata_o, mem_rdata_i, io_wdata_o, io_rdata_i, acc_o, ext_o;
	logic [17:0] index_reg_o, lockout_o, act_status_o;
	logic [15:0] mem_addr_o, ic_o, limit_o;
	logic [3:0] io_dev_o, page_o;
	int errors, n_checks;
	moe_exec dut (.core_clk_i, .srst_i, .ce_i, .start_i, .instr_i, .busy_o, .done_o,
		.minor_o, .ic_load_o, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i,
		.prot_viol_o, .io_dev_o, .io_rd_o, .io_wr_o, .io_wdata_o, .io_rdata_i, .acc_o,
		.ext_o, .index_reg_o, .decision_o, .carry_o, .overflow_o, .ic_o, .page_o,
		.limit_o, .lockout_o, .act_status_o);
	moe_mem_model u_mem (.core_clk_i(core_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
		.wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .dev_i(io_dev_o),
		.io_rd_i(io_rd_o), .io_wr_i(io_wr_o), .io_wdata_i(io_wdata_o),
		.io_rdata_o(io_rdata_i));
	// ==================================
	// shared tasks
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic rst;
		srst_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		srst_i = 1'b0;
	endtask
	// one instruction; cycles counted from the taking edge, bounded wait
	task automatic run(input logic [4:0] op, input logic [11:0] disp, input logic x,
		input int t);
		int n;
		@(negedge core_clk_i);
		start_i = 1'b1;
		instr_i = {op, x, disp};
		@(negedge core_clk_i);
		start_i = 1'b0;
		n = 1;
		while (done_o !== 1'b1 && n < 200) begin
			@(negedge core_clk_i);
			n++;
		end
		chk(18'(n), 18'(t - 1));
		@(negedge core_clk_i);
	endtask
	task automatic ld(input logic [17:0] v);
		u_mem.mem[1] = v;
		run(OPC_LOAD_ACCUMULATOR, 12'h001, 1'b0, 4);
	endtask
	// ==================================
	// scenarios
	task automatic t_loads;
		u_mem.mem[16] = 18'h2_A5A5;
		u_mem.mem[17] = 18'h0_0005;
		u_mem.mem[32] = 18'h1_1111;
		u_mem.mem[48] = 18'h2_0040;
		u_mem.mem[69] = 18'h0_BEEF;
		run(OPC_LOAD_EXTENSION, 12'h010, 1'b0, 4);
		run(OPC_LOAD_INDEX, 12'h011, 1'b0, 4);
		chk(ext_o, 18'h2_A5A5);
		chk(index_reg_o, 18'h0_0005);
		run(OPC_LOAD_ACCUMULATOR, 12'h01B, 1'b1, 6);
		chk(acc_o, 18'h1_1111);
		run(OPC_LOAD_INDIRECT, 12'h030, 1'b0, 6);
		chk(acc_o, 18'h0_BEEF);
		run(OPC_LOAD_LOCATION, 12'h7C3, 1'b0, 4);
		chk(acc_o, 18'h0_07C3);
	endtask
	task automatic t_logic;
		ld(18'h3_0F0F);
		u_mem.mem[2] = 18'h1_FF00;
		u_mem.mem[3] = 18'h2_00F0;
		run(OPC_BITWISE_AND, 12'h002, 1'b0, 4);
		chk(acc_o, 18'h1_0F00);
		run(OPC_BITWISE_OR, 12'h003, 1'b0, 4);
		chk(acc_o, 18'h3_0FF0);
	endtask
	// clock enable low in the address cycle: nothing moves, then the load ends normally
	task automatic t_freeze;
		int n;
		u_mem.mem[5] = 18'h1_2121;
		@(negedge core_clk_i);
		start_i = 1'b1;
		instr_i = {OPC_LOAD_EXTENSION, 1'b0, 12'h005};
		@(negedge core_clk_i);
		start_i = 1'b0;
		ce_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
		chk({busy_o, done_o}, 2'b10);
		ce_i = 1'b1;
		n = 1;
		while (done_o !== 1'b1 && n < 20) begin
			@(negedge core_clk_i);
			n++;
		end
		chk(18'(n), 18'h0_0003);
		chk(ext_o, 18'h1_2121);
		@(negedge core_clk_i);
	endtask
	// subtract with difference, carry and overflow worked out by hand
	task automatic sub_case(input logic [17:0] a, input logic [17:0] b, input logic [17:0] d,
		input logic c, input logic v);
		rst();
		ld(a);
		u_mem.mem[2] = b;
		run(OPC_SUBTRACT, 12'h002, 1'b0, 4);
		chk(acc_o, d);
		chk(carry_o, c);
		chk(overflow_o, v);
	endtask
	// value a sits in accumulator and index alike
	task automatic dec_case(input logic [4:0] op, input logic [17:0] a,
		input logic [17:0] b, input logic e);
		rst();
		ld(a);
		run(OPC_LOAD_INDEX, 12'h001, 1'b0, 4);
		u_mem.mem[2] = b;
		run(op, 12'h002, 1'b0, 4);
		chk(decision_o, e);
	endtask
	task automatic t_decide;
		dec_case(OPC_TEST_EQUAL, 18'h0_0005, 18'h0_0006, 1'b0);
		dec_case(OPC_TEST_EQUAL, 18'h0_0005, 18'h0_0005, 1'b1);
		u_mem.mem[2] = 18'h0_0006;
		run(OPC_TEST_EQUAL, 12'h002, 1'b0, 4);
		chk(decision_o, 1'b1);
		dec_case(OPC_TEST_GREATER, 18'h3_FFFF, 18'h0_0001, 1'b0);
		dec_case(OPC_TEST_GREATER, 18'h0_0001, 18'h3_FFFF, 1'b1);
		dec_case(OPC_TEST_LESS, 18'h3_FFFF, 18'h0_0001, 1'b1);
		dec_case(OPC_TEST_LESS, 18'h0_0001, 18'h0_0001, 1'b0);
		dec_case(OPC_TEST_INDEX_NOT_ABOVE, 18'h0_0007, 18'h0_0007, 1'b1);
		dec_case(OPC_TEST_INDEX_NOT_ABOVE, 18'h2_0000, 18'h0_0000, 1'b1);
		dec_case(OPC_TEST_INDEX_NOT_ABOVE, 18'h0_0008, 18'h0_0007, 1'b0);
	endtask
	task automatic t_shift_mul;
		rst();
		u_mem.mem[3] = 18'h3_FFFE;
		u_mem.mem[4] = 18'h0_0001;
		ld(18'h2_0002);
		run(OPC_ARITHMETIC_SHIFT, 12'h003, 1'b0, 7);
		chk(acc_o, 18'h3_8000);
		chk(overflow_o, 1'b0);
		ld(18'h1_0001);
		run(OPC_ARITHMETIC_SHIFT, 12'h004, 1'b0, 6);
		chk(acc_o, 18'h2_0002);
		chk(overflow_o, 1'b1);
		ld(18'h1_0000);
		u_mem.mem[2] = 18'h1_0000;
		run(OPC_MULTIPLY, 12'h002, 1'b0, 24);
		chk(acc_o, 18'h0_8000);
		chk(ext_o, 18'h0_0000);
	endtask
	task automatic t_io;
		rst();
		@(negedge core_clk_i);
		start_i = 1'b1;
		instr_i = 18'h0_0005;
		#1 chk(minor_o, 1'b1);
		@(negedge core_clk_i);
		start_i = 1'b0;
		u_mem.mem[64] = 18'h0_0003;
		run(OPC_INPUT_WORD_FROM_DEVICE, 12'h040, 1'b0, 6);
		chk(u_mem.mem[65], 18'h0_A5C3);
		u_mem.mem[80] = 18'h0_0001;
		u_mem.mem[81] = 18'h1_2345;
		run(OPC_OUTPUT_WORD_TO_DEVICE, 12'h050, 1'b0, 6);
		chk(u_mem.wr_dev_q, 4'h9);
		chk(u_mem.wr_data_q, 18'h1_2345);
		u_mem.mem[80] = 18'h0_0002;
		u_mem.mem[81] = 18'h2_2222;
		run(OPC_OUTPUT_WORD_TO_DEVICE, 12'h050, 1'b0, 6);
		chk(act_status_o, 18'h2_2222);
		chk(u_mem.wr_dev_q, 4'h9);
	endtask
	// restore state, then stores below and above the restored limit
	task automatic t_resume_store;
		rst();
		u_mem.mem[96] = 18'h0_0100;
		u_mem.mem[256] = 18'h0_1234;
		u_mem.mem[257] = 18'h3_8000;
		u_mem.mem[258] = 18'h0_0200;
		u_mem.mem[259] = 18'h3_0003;
		u_mem.mem[336] = 18'h0_0007;
		u_mem.mem[112] = 18'h2_0300;
		run(OPC_RESUME_FROM_INTERRUPT, 12'h060, 1'b0, 22);
		chk(ic_o, 18'h0_1234);
		chk({overflow_o, carry_o, decision_o, page_o}, 18'h0_0070);
		chk(limit_o, 18'h0_0200);
		chk(lockout_o, 18'h3_0003);
		ld(18'h0_0010);
		run(OPC_LOAD_INDEX, 12'h001, 1'b0, 4);
		run(OPC_LOAD_EXTENSION, 12'h001, 1'b0, 4);
		ld(18'h1_5555);
		run(OPC_STORE_ACCUMULATOR, 12'h150, 1'b0, 6);
		run(OPC_STORE_EXTENSION, 12'h150, 1'b0, 6);
		chk(u_mem.mem[336], 18'h0_0007);
		run(OPC_STORE_ACCUMULATOR, 12'h300, 1'b0, 6);
		chk(u_mem.mem[768], 18'h1_5555);
		run(OPC_STORE_EXTENSION, 12'h320, 1'b0, 6);
		chk(u_mem.mem[800], 18'h0_0010);
		run(OPC_STORE_INDEX, 12'h310, 1'b0, 6);
		chk(u_mem.mem[784], 18'h0_0010);
		run(OPC_STORE_INDIRECT, 12'h070, 1'b0, 8);
		chk(u_mem.mem[784], 18'h1_5555);
	endtask
	// ==================================
	// clock, watchdog and main sequence
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		#100000;
		errors++;
		final_report();
	end
	initial begin
		errors = 0;
		n_checks = 0;
		ce_i = 1'b1;
		start_i = 1'b0;
		instr_i = 18'h0_0000;
		rst();
		t_loads();
		t_logic();
		t_freeze();
		sub_case(18'h0_0005, 18'h0_0002, 18'h0_0003, 1'b1, 1'b0);
		sub_case(18'h0_0001, 18'h0_0002, 18'h3_FFFF, 1'b0, 1'b0);
		sub_case(18'h1_FFFF, 18'h3_FFFF, 18'h2_0000, 1'b1, 1'b1);
		sub_case(18'h2_0000, 18'h0_0001, 18'h1_FFFF, 1'b0, 1'b1);
		t_decide();
		t_shift_mul();
		t_io();
		t_resume_store();
		final_report();
	end
endmodule

// [test/moe_mem_model.sv]
// memory and input/output device partner for the execution unit
`timescale 1ns/1ps
module moe_mem_model (
	input wire logic core_clk_i,
	input wire logic [15:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [17:0] wdata_i,
	output logic [17:0] rdata_o,
	input wire logic [3:0] dev_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [17:0] io_wdata_i,
	output logic [17:0] io_rdata_o
);
	logic [17:0] mem [0:4095];
	logic [3:0] wr_dev_q;
	logic [17:0] wr_data_q;
	// ==================================
	// read data valid for one cycle, then inverted on every later cycle, so a stale word comes back every second cycle
	initial begin
		rdata_o = 18'h0_0000;
		io_rdata_o = 18'h0_0000;
		wr_dev_q = 4'h0;
	end
	always @(posedge core_clk_i) begin
		rdata_o <= rd_i ? mem[addr_i[11:0]] : ~rdata_o;
		io_rdata_o <= io_rd_i ? {14'h0A5C, dev_i} : ~io_rdata_o;
		if (wr_i) begin
			mem[addr_i[11:0]] <= wdata_i;
		end
		if (io_wr_i) begin
			wr_dev_q <= dev_i;
			wr_data_q <= io_wdata_i;
		end
	end
endmodule
